// ### hdl/reset_seq_params.svh
// timing counts, pin codes and reset values of the reset and clock start-up sequencer
`ifndef RESET_SEQ_PARAMS_SVH
`define RESET_SEQ_PARAMS_SVH

`define SYS_CLK_HZ 50000000
`define FAST_OSC_HZ 4000000
`define SLOW_OSC_HZ 48000
`define FAST_DIV (`SYS_CLK_HZ / `FAST_OSC_HZ)
`define SLOW_DIV (`SYS_CLK_HZ / `SLOW_OSC_HZ)
`define POWERUP_TIMER_TIME_MS 72
`define POWERUP_TIMER_CYCLES (`POWERUP_TIMER_TIME_MS * (`SYS_CLK_HZ / 1000))
`define OST_OSC_CYCLES 1024
`define OLD_SPEED_PULSES 2
`define NEW_SPEED_PULSES 8
`define CLOCK_OUTPUT_PIN_DIV 4
`define BOR_MIN_CYCLES 100
`define PIN_FILTER_CYCLES 16

`define OSC_RC_CLOCK_OUTPUT_PIN 3'h7
`define OSC_RC_IO 3'h6
`define OSC_INT_CLOCK_OUTPUT_PIN 3'h5
`define OSC_INT_IO 3'h4
`define OSC_EXT_CLOCK 3'h3
`define OSC_HS_XTAL 3'h2
`define OSC_STD_XTAL 3'h1
`define OSC_LP_XTAL 3'h0

`define FAST_SELECT_RESET 1'b1
`define POWER_ON_FLAG_RESET 1'b0
`define BROWNOUT_FLAG_RESET 1'b0

`endif

// ### hdl/reset_seq_pkg.sv
// types of the reset and clock start-up sequencer
`default_nettype none
package reset_seq_pkg;
  typedef enum logic [2:0] {
    cause_power_on,
    cause_pin_run,
    cause_pin_sleep,
    cause_watchdog,
    cause_watchdog_wake,
    cause_brownout
  } reset_cause_t;

  typedef enum logic [2:0] {st_power, st_hold, st_powerup, st_oscwait, st_run} seq_state_t;

  typedef enum logic [1:0] {ck_run, ck_old, ck_new} clk_phase_t;
endpackage
`default_nettype wire

// ### hdl/reset_and_clock_startup_sequencer.sv
// reset cause tracking, start-up timers and dual-speed system clock control
//
// What this block does
// - RC mode: second oscillator pin is I/O or clock divided by four.
// - software picks 4 MHz or 48 kHz system clock, internal oscillator mode only.
// - speed change takes two old-speed pulses then eight new-speed pulses.
// - system clock, and clock output, are halted during the speed change.
// - one fast clock select bit chooses the internal oscillator speed.
// - six reset causes are told apart and reported.
// - registers reset on every cause except watchdog wake-up from sleep.
// - some storage is never reset and keeps its value across resets.
// - external reset pin is glitch filtered.
// - held in reset until supply rise is seen; a later low rise detect also gives reset.
// - power-up timer holds reset 72 ms after power-on or enabled brown-out.
// - power-up timer disable bit 1 disables, 0 enables.
// - after power-up timer, 1024 first oscillator pin cycles before execution.
// - start-up timer only in crystal modes, on power-on or watchdog wake-up from sleep.
// - brown-out enable bit 1 enables, 0 disables brown-out reset.
// - reset only when supply stays below threshold beyond minimum duration.
// - any reset except watchdog wake-up from sleep waits for supply above threshold; power-up timer follows only power-on or brown-out.
// - brown-out during power-up timer restarts it after recovery.
// - internal oscillator mode gives a 4 MHz system clock while fast select is 1, its reset value.
// - oscillator select codes 111, 110, 101, 100 as listed.
// - status register holds fast select, power-on and brown-out flags.
// - power-on flag reads 0 after power-on; software sets it to 1.
`include "reset_seq_params.svh"
`default_nettype none

module reset_and_clock_startup_sequencer #(
  parameter int unsigned POWERUP_TIMER_CYCLES = `POWERUP_TIMER_CYCLES,
  parameter int unsigned OST_CYCLES  = `OST_OSC_CYCLES,
  parameter int unsigned BOR_MIN     = `BOR_MIN_CYCLES,
  parameter int unsigned PIN_FILTER  = `PIN_FILTER_CYCLES
) (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        power_rise_detect,
  input  wire logic                        brownout_below,
  input  wire logic                        external_reset_pin_n,
  input  wire logic                        first_osc_pin,
  input  wire logic                        watchdog_timeout,
  input  wire logic                        sleep_active,
  input  wire logic [2:0]                  osc_select,
  input  wire logic                        powerup_timer_disable,
  input  wire logic                        brownout_enable,
  input  wire logic                        fast_select_write,
  input  wire logic                        fast_select_wdata,
  input  wire logic                        power_on_flag_set,
  input  wire logic                        brownout_flag_set,
  input  wire logic                        retained_write,
  input  wire logic [7:0]                  retained_wdata,
  output logic                             core_reset,
  output logic                             regs_reset,
  output reset_seq_pkg::reset_cause_t      reset_cause,
  output logic                             power_on_flag,
  output logic                             brownout_flag,
  output logic                             fast_clock_select,
  output logic                             clock_halted,
  output logic                             sys_tick,
  output logic                             clock_output_pin,
  output logic                             clock_output_oe,
  output logic                             second_osc_gpio,
  output logic [7:0]                       retained_data
);

  localparam int PW_W  = $clog2(POWERUP_TIMER_CYCLES + 1);
  localparam int OST_W = $clog2(OST_CYCLES + 1);
  localparam int BO_W  = $clog2(BOR_MIN + 1);
  localparam int PF_W  = $clog2(PIN_FILTER + 1);
  localparam int DIV_W = $clog2(`SLOW_DIV + 1);
  localparam logic [DIV_W-1:0] FAST_LIM = DIV_W'(`FAST_DIV - 1);
  localparam logic [DIV_W-1:0] SLOW_LIM = DIV_W'(`SLOW_DIV - 1);
  localparam logic [3:0] OLD_LIM = 4'(`OLD_SPEED_PULSES - 1);
  localparam logic [3:0] NEW_LIM = 4'(`NEW_SPEED_PULSES - 1);
  localparam logic [1:0] CO_LIM  = 2'(`CLOCK_OUTPUT_PIN_DIV - 1);

  function automatic logic is_crystal(input logic [2:0] sel);
    is_crystal = (sel == `OSC_LP_XTAL) || (sel == `OSC_STD_XTAL) || (sel == `OSC_HS_XTAL);
  endfunction

  function automatic logic is_internal(input logic [2:0] sel);
    is_internal = (sel == `OSC_INT_CLOCK_OUTPUT_PIN) || (sel == `OSC_INT_IO);
  endfunction

  // pins and analog detectors come from outside the clock domain
  logic [1:0] por_sync_q;
  logic [1:0] bo_sync_q;
  logic [1:0] pin_sync_q;
  logic [1:0] osc_sync_q;
  logic       osc_prev_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      por_sync_q <= 2'h0;
      bo_sync_q  <= 2'h0;
      pin_sync_q <= 2'h0;
      osc_sync_q <= 2'h0;
      osc_prev_q <= 1'b0;
    end else begin
      por_sync_q <= {por_sync_q[0], power_rise_detect};
      bo_sync_q  <= {bo_sync_q[0], brownout_below};
      pin_sync_q <= {pin_sync_q[0], external_reset_pin_n};
      osc_sync_q <= {osc_sync_q[0], first_osc_pin};
      osc_prev_q <= osc_sync_q[1];
    end
  end

  logic supply_up;
  logic bo_low;
  logic osc_edge;
  assign supply_up = por_sync_q[1];
  assign bo_low    = bo_sync_q[1] & brownout_enable;
  assign osc_edge  = osc_sync_q[1] & ~osc_prev_q;

  // pin level is adopted only after it has stood still for the filter time
  logic [PF_W-1:0] pin_cnt_q;
  logic            pin_filt_q;
  logic            pin_prev_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_cnt_q  <= '0;
      pin_filt_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_filt_q;
      if (pin_sync_q[1] == pin_filt_q) begin
        pin_cnt_q <= '0;
      end else if (pin_cnt_q == PF_W'(PIN_FILTER - 1)) begin
        pin_cnt_q  <= '0;
        pin_filt_q <= pin_sync_q[1];
      end else begin
        pin_cnt_q <= pin_cnt_q + PF_W'(1);
      end
    end
  end

  logic pin_fall;
  assign pin_fall = pin_prev_q & ~pin_filt_q;

  // brown-out has to last beyond the minimum duration before it counts
  logic [BO_W-1:0] bo_cnt_q;
  logic            bo_qual;
  assign bo_qual = (bo_cnt_q == BO_W'(BOR_MIN));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bo_cnt_q <= '0;
    end else if (!bo_low) begin
      bo_cnt_q <= '0;
    end else if (!bo_qual) begin
      bo_cnt_q <= bo_cnt_q + BO_W'(1);
    end
  end

  // reset sequence
  reset_seq_pkg::seq_state_t   state_q;
  reset_seq_pkg::seq_state_t   state_d;
  reset_seq_pkg::reset_cause_t cause_q;
  reset_seq_pkg::reset_cause_t cause_d;
  logic [PW_W-1:0]             powerup_timer_cnt_q;
  logic [OST_W-1:0]            ost_cnt_q;
  logic                        powerup_timer_done;
  logic                        ost_done;
  logic                        ost_use;
  logic                        powerup_timer_use;

  assign powerup_timer_done = (powerup_timer_cnt_q == PW_W'(POWERUP_TIMER_CYCLES - 1));
  assign ost_done  = osc_edge && (ost_cnt_q == OST_W'(OST_CYCLES - 1));
  assign powerup_timer_use  = !powerup_timer_disable && (cause_q == reset_seq_pkg::cause_power_on ||
                     cause_q == reset_seq_pkg::cause_brownout);
  assign ost_use   = is_crystal(osc_select) && (cause_q == reset_seq_pkg::cause_power_on ||
                     cause_q == reset_seq_pkg::cause_watchdog_wake);

  always_comb begin
    state_d = state_q;
    cause_d = cause_q;
    if (!supply_up) begin
      state_d = reset_seq_pkg::st_power;
      cause_d = reset_seq_pkg::cause_power_on;
    end else begin
      unique case (state_q)
        reset_seq_pkg::st_power: begin
          state_d = reset_seq_pkg::st_hold;
        end
        reset_seq_pkg::st_hold: begin
          if (!bo_low) begin
            if (powerup_timer_use) begin
              state_d = reset_seq_pkg::st_powerup;
            end else if (ost_use) begin
              state_d = reset_seq_pkg::st_oscwait;
            end else begin
              state_d = reset_seq_pkg::st_run;
            end
          end
        end
        reset_seq_pkg::st_powerup: begin
          if (bo_low) begin
            state_d = reset_seq_pkg::st_hold;
            cause_d = reset_seq_pkg::cause_brownout;
          end else if (powerup_timer_done) begin
            state_d = ost_use ? reset_seq_pkg::st_oscwait : reset_seq_pkg::st_run;
          end
        end
        reset_seq_pkg::st_oscwait: begin
          if (ost_done) begin
            state_d = reset_seq_pkg::st_run;
          end
        end
        reset_seq_pkg::st_run: begin
          if (bo_qual) begin
            state_d = reset_seq_pkg::st_hold;
            cause_d = reset_seq_pkg::cause_brownout;
          end else if (pin_fall) begin
            state_d = reset_seq_pkg::st_hold;
            cause_d = sleep_active ? reset_seq_pkg::cause_pin_sleep : reset_seq_pkg::cause_pin_run;
          end else if (watchdog_timeout && sleep_active) begin
            cause_d = reset_seq_pkg::cause_watchdog_wake;
            if (is_crystal(osc_select)) begin
              state_d = reset_seq_pkg::st_oscwait;
            end
          end else if (watchdog_timeout) begin
            state_d = reset_seq_pkg::st_hold;
            cause_d = reset_seq_pkg::cause_watchdog;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= reset_seq_pkg::st_power;
      cause_q <= reset_seq_pkg::cause_power_on;
    end else begin
      state_q <= state_d;
      cause_q <= cause_d;
    end
  end

  // a fresh entry always starts the timers from zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      powerup_timer_cnt_q <= '0;
      ost_cnt_q  <= '0;
    end else begin
      if (state_q != reset_seq_pkg::st_powerup || state_d != reset_seq_pkg::st_powerup) begin
        powerup_timer_cnt_q <= '0;
      end else begin
        powerup_timer_cnt_q <= powerup_timer_cnt_q + PW_W'(1);
      end
      if (state_q != reset_seq_pkg::st_oscwait) begin
        ost_cnt_q <= '0;
      end else if (osc_edge) begin
        ost_cnt_q <= ost_cnt_q + OST_W'(1);
      end
    end
  end

  logic reset_d;
  assign reset_d = (state_d != reset_seq_pkg::st_run) || !pin_filt_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      core_reset  <= 1'b1;
      regs_reset  <= 1'b1;
      reset_cause <= reset_seq_pkg::cause_power_on;
    end else begin
      core_reset  <= reset_d;
      regs_reset  <= reset_d && (cause_d != reset_seq_pkg::cause_watchdog_wake);
      reset_cause <= cause_d;
    end
  end

  // status flags: the reset event wins over a software set in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      power_on_flag <= `POWER_ON_FLAG_RESET;
    end else if (state_q == reset_seq_pkg::st_power) begin
      power_on_flag <= 1'b0;
    end else if (power_on_flag_set) begin
      power_on_flag <= 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      brownout_flag <= `BROWNOUT_FLAG_RESET;
    end else if (cause_d == reset_seq_pkg::cause_brownout && reset_d) begin
      brownout_flag <= 1'b0;
    end else if (brownout_flag_set) begin
      brownout_flag <= 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fast_clock_select <= `FAST_SELECT_RESET;
    end else if (fast_select_write) begin
      fast_clock_select <= fast_select_wdata;
    end
  end

  // kept across every reset, so it is undefined until first written
  always_ff @(posedge clock) begin
    if (retained_write) begin
      retained_data <= retained_wdata;
    end
  end

  // internal oscillator and speed change
  reset_seq_pkg::clk_phase_t phase_q;
  logic                      speed_q;
  logic [DIV_W-1:0]          div_cnt_q;
  logic [3:0]                pulse_cnt_q;
  logic                      int_tick;
  logic                      src_tick;

  assign int_tick = (div_cnt_q == (speed_q ? FAST_LIM : SLOW_LIM));
  assign src_tick = is_internal(osc_select) ? int_tick : osc_edge;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_cnt_q <= '0;
    end else if (int_tick) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + DIV_W'(1);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_q     <= reset_seq_pkg::ck_run;
      speed_q     <= `FAST_SELECT_RESET;
      pulse_cnt_q <= 4'h0;
    end else begin
      unique case (phase_q)
        reset_seq_pkg::ck_run: begin
          if (is_internal(osc_select) && fast_clock_select != speed_q) begin
            phase_q     <= reset_seq_pkg::ck_old;
            pulse_cnt_q <= 4'h0;
          end
        end
        reset_seq_pkg::ck_old: begin
          if (int_tick && pulse_cnt_q == OLD_LIM) begin
            phase_q     <= reset_seq_pkg::ck_new;
            speed_q     <= ~speed_q;
            pulse_cnt_q <= 4'h0;
          end else if (int_tick) begin
            pulse_cnt_q <= pulse_cnt_q + 4'h1;
          end
        end
        reset_seq_pkg::ck_new: begin
          if (int_tick && pulse_cnt_q == NEW_LIM) begin
            phase_q <= reset_seq_pkg::ck_run;
          end else if (int_tick) begin
            pulse_cnt_q <= pulse_cnt_q + 4'h1;
          end
        end
      endcase
    end
  end

  // clock output runs off the gated tick, so it freezes with the core
  logic [1:0] co_cnt_q;
  logic       halt_d;
  logic       out_clk;
  assign halt_d  = (phase_q != reset_seq_pkg::ck_run);
  assign out_clk = (osc_select == `OSC_RC_CLOCK_OUTPUT_PIN) || (osc_select == `OSC_INT_CLOCK_OUTPUT_PIN);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clock_halted     <= 1'b0;
      sys_tick         <= 1'b0;
      co_cnt_q         <= 2'h0;
      clock_output_pin <= 1'b0;
    end else begin
      clock_halted <= halt_d;
      sys_tick     <= src_tick && !halt_d;
      if (src_tick && !halt_d) begin
        co_cnt_q <= (co_cnt_q == CO_LIM) ? 2'h0 : co_cnt_q + 2'h1;
      end
      clock_output_pin <= out_clk && co_cnt_q[1];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clock_output_oe <= 1'b0;
      second_osc_gpio <= 1'b0;
    end else begin
      clock_output_oe <= out_clk;
      second_osc_gpio <= (osc_select == `OSC_RC_IO) || (osc_select == `OSC_INT_IO) ||
                         (osc_select == `OSC_EXT_CLOCK);
    end
  end

endmodule
`default_nettype wire

// ### verification/far_side_model.sv
// behavioural far side: supply detectors, external reset pin and oscillator
`default_nettype none
module far_side_model (
  input  wire logic supply_on,
  input  wire logic dip,
  input  wire logic pin_n,
  input  wire logic osc_run,
  output logic      power_rise_detect,
  output logic      brownout_below,
  output logic      external_reset_pin_n,
  output logic      first_osc_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  assign power_rise_detect = supply_on;
  assign brownout_below = dip;
  // pin level is passed straight through; the bench drives it high to release it
  assign external_reset_pin_n = pin_n;
  // period unrelated to the system clock; a stopped oscillator sits low
  initial begin
    first_osc_pin = 1'b0;
    forever begin
      #37;
      first_osc_pin = osc_run ? ~first_osc_pin : 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### verification/sequencer_checker.sv
// concurrent checks on the ports of the reset and clock start-up sequencer
`default_nettype none
module sequencer_checker #(
  parameter int unsigned POWERUP_TIMER_CYCLES = 50,
  parameter int unsigned PIN_FILTER  = 4
) (
  input wire logic                        clock,
  input wire logic                        rst,
  input wire logic                        power_rise_detect,
  input wire logic                        external_reset_pin_n,
  input wire logic [2:0]                  osc_select,
  input wire logic                        powerup_timer_disable,
  input wire logic                        core_reset,
  input wire logic                        regs_reset,
  input wire reset_seq_pkg::reset_cause_t reset_cause,
  input wire logic                        clock_halted,
  input wire logic                        sys_tick,
  input wire logic                        clock_output_oe,
  input wire logic                        second_osc_gpio
);
  // shortest halt is ten fast ticks less one; longest is ten slow ticks plus slack
  localparam int unsigned HALT_MIN = 108;
  localparam int unsigned HALT_MAX = 10450;
  int unsigned pin_low_q;
  int unsigned hi_q;
  int unsigned halt_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_low_q <= 0;
      hi_q <= 0;
      halt_q <= 0;
    end else begin
      pin_low_q <= external_reset_pin_n ? 0 : pin_low_q + 1;
      hi_q <= core_reset ? hi_q + 1 : 0;
      halt_q <= clock_halted ? halt_q + 1 : 0;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  AST_REGS_IN_CORE: assert property (regs_reset |-> core_reset)
    else $error("register reset without core reset");
  AST_HALT_NO_TICK: assert property (clock_halted |-> !sys_tick)
    else $error("system tick while clock halted");
  AST_HALT_INTERNAL_OSC_MODE: assert property (clock_halted |-> osc_select[2:1] == 2'h2)
    else $error("speed change outside internal oscillator mode");
  AST_OE_MODE: assert property (1'b1 |=> clock_output_oe == (osc_select inside {3'h7, 3'h5}))
    else $error("clock output enable does not match mode");
  AST_GPIO_MODE: assert property (1'b1 |=> second_osc_gpio == (osc_select inside {3'h6, 3'h4, 3'h3}))
    else $error("second pin io does not match mode");
  AST_SUPPLY_LOW: assert property (!power_rise_detect [*4] |=> core_reset)
    else $error("no reset while supply not risen");
  AST_PIN_HOLD: assert property (pin_low_q >= PIN_FILTER + 6 |-> core_reset)
    else $error("core runs while reset pin held low");
  AST_POWERUP_TIMER_HOLD: assert property ($fell(core_reset) && !powerup_timer_disable
      && reset_cause == reset_seq_pkg::cause_power_on |-> hi_q >= POWERUP_TIMER_CYCLES)
    else $error("power-up hold too short");
  AST_HALT_MIN: assert property ($fell(clock_halted) |-> halt_q >= HALT_MIN)
    else $error("speed change halt too short");
  AST_HALT_MAX: assert property (halt_q <= HALT_MAX)
    else $error("speed change halt too long");
endmodule
bind reset_and_clock_startup_sequencer sequencer_checker #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER_CYCLES), .PIN_FILTER(PIN_FILTER)) chk (
  .clock, .rst, .power_rise_detect, .external_reset_pin_n, .osc_select, .powerup_timer_disable, .core_reset,
  .regs_reset, .reset_cause, .clock_halted, .sys_tick, .clock_output_oe, .second_osc_gpio);
`default_nettype wire

// ### verification/test_reset_and_clock_startup_sequencer.sv
// self-checking bench of the reset and clock start-up sequencer
`include "reset_seq_params.svh"
`default_nettype none
module test_reset_and_clock_startup_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PW = 50;
  logic clock, rst, watchdog_timeout, sleep_active, fast_select_write, fast_select_wdata;
  logic power_on_flag_set, brownout_flag_set, retained_write, powerup_timer_disable, brownout_enable;
  logic supply_on, dip, pin_n, osc_run, power_rise_detect, brownout_below, external_reset_pin_n, first_osc_pin;
  logic core_reset, regs_reset, power_on_flag, brownout_flag, fast_clock_select, clock_halted, sys_tick;
  logic clock_output_pin, clock_output_oe, second_osc_gpio, p, seen;
  logic [2:0]                  osc_select;
  logic [7:0]                  retained_wdata, retained_data, kept;
  logic [15:0]                 lf;
  reset_seq_pkg::reset_cause_t reset_cause;
  int                          n_errors, n_checks, t, k, r;
  far_side_model fsm (.supply_on, .dip, .pin_n, .osc_run, .power_rise_detect, .brownout_below,
    .external_reset_pin_n, .first_osc_pin);
  reset_and_clock_startup_sequencer #(.POWERUP_TIMER_CYCLES(PW), .OST_CYCLES(8), .BOR_MIN(4), .PIN_FILTER(4)) uut (
    .clock, .rst, .power_rise_detect, .brownout_below, .external_reset_pin_n, .first_osc_pin,
    .watchdog_timeout, .sleep_active, .osc_select, .powerup_timer_disable, .brownout_enable,
    .fast_select_write, .fast_select_wdata, .power_on_flag_set, .brownout_flag_set, .retained_write,
    .retained_wdata, .core_reset, .regs_reset, .reset_cause, .power_on_flag, .brownout_flag,
    .fast_clock_select, .clock_halted, .sys_tick, .clock_output_pin, .clock_output_oe, .second_osc_gpio,
    .retained_data);
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic exp_oe(input logic [2:0] c);
    return c == 3'h7 || c == 3'h5;
  endfunction
  function automatic logic exp_gpio(input logic [2:0] c);
    return c == 3'h6 || c == 3'h4 || c == 3'h3;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask
  task automatic chk_cause(input reset_seq_pkg::reset_cause_t exp);
    n_checks++;
    if (reset_cause !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t cause %0d", $time, reset_cause);
    end
  endtask
  task automatic chk_range(input int v, input int lo, input int hi, input string what);
    n_checks++;
    if (v < lo || v > hi) begin
      n_errors++;
      $display("CHECK FAILED %0t %s %0d", $time, what, v);
    end
  endtask
  task automatic till_run(input int lim);
    t = 0;
    while (core_reset !== 1'b0 && t < lim) begin
      cyc(1);
      t++;
    end
  endtask
  task automatic power_up(input logic [2:0] code);
    rst = 1'b1;
    supply_on = 1'b0;
    osc_select = code;
    cyc(10);
    rst = 1'b0;
    // supply stays low long enough for the supply-low check to see it
    cyc(5);
    supply_on = 1'b1;
  endtask
  // counts ticks and halt length; the tick rate follows the oscillator mode and speed select
  task automatic count_ticks(input int n);
    k = 0;
    repeat (n) begin
      cyc(1);
      k += int'(sys_tick);
    end
  endtask
  task automatic halt_len;
    t = 0;
    while (clock_halted === 1'b1 && t < 12000) begin
      cyc(1);
      t++;
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    #1ms;
    n_errors++;
    final_report;
  end
  initial begin
    {watchdog_timeout, sleep_active, fast_select_write, fast_select_wdata, power_on_flag_set} = '0;
    {brownout_flag_set, retained_write, retained_wdata, dip, osc_run, supply_on} = '0;
    {powerup_timer_disable, brownout_enable} = 2'h1;
    {rst, pin_n, osc_select} = {2'h3, 3'h7};
    lf = 16'h0f6c;
    for (int c = 0; c < 8; c++) begin
      power_up(3'(c));
      cyc(3);
      chk1(clock_output_oe, exp_oe(3'(c)), "oe");
      chk1(second_osc_gpio, exp_gpio(3'(c)), "gpio");
    end
    powerup_timer_disable = 1'b1;
    power_up(3'h6);
    till_run(2000);
    chk_range(t, 1, PW - 10, "no timer");
    powerup_timer_disable = 1'b0;
    osc_run = 1'b1;
    power_up(3'h7);
    till_run(2000);
    chk_range(t, PW, PW + 40, "timer");
    chk_cause(reset_seq_pkg::cause_power_on);
    chk1(power_on_flag, 1'b0, "power flag");
    r = 0;
    p = clock_output_pin;
    count_ticks(0);
    repeat (400) begin
      cyc(1);
      k += int'(sys_tick);
      r += int'(clock_output_pin && !p);
      p = clock_output_pin;
    end
    chk_range(k - 4 * r, -4, 8, "clock_output_pin ratio");
    chk_range(r, 5, 200, "clock_output_pin runs");
    pulse(power_on_flag_set);
    retained_wdata = lf[7:0];
    kept = lf[7:0];
    pulse(retained_write);
    lf = lfsr(lf);
    pin_n = 1'b0;
    cyc(1 + int'(lf[0]));
    pin_n = 1'b1;
    cyc(12);
    chk1(core_reset, 1'b0, "glitch");
    for (int s = 0; s < 2; s++) begin
      sleep_active = s[0];
      pin_n = 1'b0;
      cyc(12);
      chk1(regs_reset, 1'b1, "pin regs");
      chk_cause(s ? reset_seq_pkg::cause_pin_sleep : reset_seq_pkg::cause_pin_run);
      pin_n = 1'b1;
      sleep_active = 1'b0;
      till_run(40);
      chk_range(t, 1, 20, "pin release");
    end
    chk1(power_on_flag, 1'b1, "power flag kept");
    for (int s = 0; s < 2; s++) begin
      sleep_active = s[0];
      pulse(watchdog_timeout);
      // the watchdog reset lasts one cycle and already stands when the pulse ends
      seen = regs_reset;
      repeat (6) begin
        cyc(1);
        seen |= regs_reset;
      end
      chk1(seen, !s[0], "watchdog regs");
      chk_cause(s ? reset_seq_pkg::cause_watchdog_wake : reset_seq_pkg::cause_watchdog);
      sleep_active = 1'b0;
      cyc(20);
    end
    pulse(brownout_flag_set);
    chk1(brownout_flag, 1'b1, "brownout flag set");
    dip = 1'b1;
    cyc(2);
    dip = 1'b0;
    cyc(10);
    chk1(core_reset, 1'b0, "short dip");
    lf = lfsr(lf);
    dip = 1'b1;
    cyc(12 + int'(lf[2:0]));
    chk1(core_reset, 1'b1, "long dip");
    chk_cause(reset_seq_pkg::cause_brownout);
    chk1(brownout_flag, 1'b0, "brownout flag");
    dip = 1'b0;
    cyc(20);
    dip = 1'b1;
    cyc(12);
    dip = 1'b0;
    till_run(2000);
    chk_range(t, PW, PW + 40, "timer restart");
    chk1(retained_data === kept, 1'b1, "retained");
    brownout_enable = 1'b0;
    dip = 1'b1;
    cyc(20);
    chk1(core_reset, 1'b0, "brownout off");
    dip = 1'b0;
    brownout_enable = 1'b1;
    osc_run = 1'b0;
    power_up(3'h1);
    cyc(PW + 40);
    chk1(core_reset, 1'b1, "osc wait");
    osc_run = 1'b1;
    till_run(200);
    chk_range(t, 20, 100, "osc count");
    power_up(3'h5);
    till_run(2000);
    count_ticks(20 * `FAST_DIV);
    chk_range(k, 19, 21, "fast ticks");
    for (int s = 0; s < 2; s++) begin
      fast_select_wdata = s[0];
      pulse(fast_select_write);
      cyc(2);
      chk1(clock_halted, 1'b1, "halted");
      chk1(fast_clock_select, s[0], "select");
      halt_len;
      chk_range(t, s ? `SLOW_DIV + 8 * `FAST_DIV : 8 * `SLOW_DIV,
                s ? 3 * `SLOW_DIV + 8 * `FAST_DIV : 8 * `SLOW_DIV + 3 * `FAST_DIV, "halt");
      count_ticks(2 * `SLOW_DIV);
      chk_range(k, s ? 160 : 1, s ? 180 : 3, "speed");
    end
    final_report;
  end
endmodule
`default_nettype wire
